/* bench/fifo_control_flags_reset_checker.sv */
`timescale 1ns/1ps
module fifo_control_flags_reset_checker
   import fifo_ctl_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire pins_t       pins_i,
   input wire logic        output_drive_n_i,
   input wire logic [17:0] read_data_out_o,
   input wire logic        read_data_oe_n_o,
   input wire logic        empty_indicator_n_o,
   input wire logic        almost_empty_flag_o,
   input wire logic        almost_full_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_oe_follow;
      read_data_oe_n_o == output_drive_n_i;
   endproperty
   a_oe_follow: assert property (p_oe_follow)
      else $error("output enable not passed through");

   property p_full_out;
      (!pins_i.full_reset_n)[*6] |=>
         read_data_out_o == 18'h0 && !empty_indicator_n_o;
   endproperty
   a_full_out: assert property (p_full_out)
      else $error("full reset left data or pointers");

   property p_full_flags;
      (!pins_i.full_reset_n)[*6] |=>
         !almost_empty_flag_o && almost_full_flag_o;
   endproperty
   a_full_flags: assert property (p_full_flags)
      else $error("flags wrong for an empty store");

   property p_part_out;
      (!pins_i.partial_clear_n)[*6] |=>
         read_data_out_o == 18'h0 && !empty_indicator_n_o;
   endproperty
   a_part_out: assert property (p_part_out)
      else $error("partial reset left data or pointers");

   // data out may only move on a read event or a reset
   property p_out_quiet;
      (!pins_i.read_clock && pins_i.full_reset_n
         && pins_i.partial_clear_n)[*8] |=> $stable(read_data_out_o);
   endproperty
   a_out_quiet: assert property (p_out_quiet)
      else $error("data out moved without read event");

   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("bus request not acked next cycle");

   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");

   property p_no_stray;
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
   endproperty
   a_no_stray: assert property (p_no_stray)
      else $error("ack without request");
endmodule : fifo_control_flags_reset_checker

bind fifo_control_flags_reset fifo_control_flags_reset_checker u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pins_i(pins_i),
   .output_drive_n_i(output_drive_n_i),
   .read_data_out_o(read_data_out_o),
   .read_data_oe_n_o(read_data_oe_n_o),
   .empty_indicator_n_o(empty_indicator_n_o),
   .almost_empty_flag_o(almost_empty_flag_o),
   .almost_full_flag_o(almost_full_flag_o)
);

/* bench/fifo_control_flags_reset_tb.sv */
`timescale 1ns/1ps
`include "fifo_ctl_defs.svh"
`define CHK(a, b) \
   begin \
      checks_done++; \
      if ((a) !== (b)) \
      begin \
         failures++; \
         $display("[ERR] %0t got %0h exp %0h", $time, a, b); \
      end \
   end
module fifo_control_flags_reset_tb
   import fifo_ctl_pkg::*;
();
   logic        clk_i, rst_i, cyc, stb, we, wr_en, oe_n, rd_req;
   logic        rc, busy, wb_ack_o, irq_o, wr_full_o, read_data_oe_n_o;
   logic        empty_indicator_n_o, almost_empty_flag_o;
   logic        almost_full_flag_o;
   logic [7:0]  adr;
   logic [31:0] dat, q, wb_dat_o;
   logic [17:0] wdat, read_data_out_o;
   logic [11:0] e;
   pins_t       pins, pins_w;
   config_t     cf;
   int          failures, checks_done;

   assign pins_w = {pins[17:1], rc};

   fifo_control_flags_reset u_fifo_control_flags_reset (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
      .pins_i(pins_w), .output_drive_n_i(oe_n), .wr_en_i(wr_en),
      .wr_data_i(wdat), .wr_full_o(wr_full_o),
      .read_data_out_o(read_data_out_o),
      .read_data_oe_n_o(read_data_oe_n_o),
      .empty_indicator_n_o(empty_indicator_n_o),
      .almost_empty_flag_o(almost_empty_flag_o),
      .almost_full_flag_o(almost_full_flag_o));

   fifo_far_side u_fifo_far_side (.clk_i(clk_i), .rd_req_i(rd_req),
      .read_clock_o(rc), .busy_o(busy));

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic ck(input int n);
      repeat (n) @(posedge clk_i);
   endtask : ck

   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a;
      we  <= w;
      dat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      // a bus that never answers counts against the run
      if (wb_ack_o !== 1'b1)
         failures++;
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      ck(1);
   endtask : wb

   task automatic wr(input logic [17:0] d);
      wr_en <= 1'b1;
      wdat  <= d;
      ck(1);
      wr_en <= 1'b0;
      ck(1);
   endtask : wr

   task automatic rd_ev;
      int n;
      n = 0;
      rd_req <= 1'b1;
      ck(1);
      rd_req <= 1'b0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (busy && n < 20);
      if (busy)
         failures++;
      ck(2);
   endtask : rd_ev

   // full reset with width, offset and flag timing pins from one code
   task automatic fr(input logic [2:0] c);
      pins.default_offset_sel_a <= c[0];
      pins.default_offset_sel_b <= c[1];
      pins.offset_load_select_n <= c[2];
      pins.input_width_select   <= c[0];
      pins.output_width_select  <= c[1];
      pins.flag_timing_select   <= c[2];
      pins.full_reset_n <= 1'b0;
      ck(8);
      pins.full_reset_n <= 1'b1;
      ck(6);
      pins.offset_load_select_n <= 1'b1;
      ck(5);
   endtask : fr

   task automatic give_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   initial
   begin
      #400000;
      failures++;
      give_verdict();
   end

   initial
   begin
      {cyc, stb, we, wr_en, oe_n, rd_req} = 6'h0;
      {adr, dat, wdat} = '0;
      // resets released, sync read, read gate held low
      pins = pins_t'(18'h381C4);
      rst_i = 1'b1;
      ck(2);
      rst_i <= 1'b0;
      ck(4);
      for (int i = 7; i >= 0; i--)
      begin
         fr(3'(i));
         `CHK(read_data_out_o, 18'h0)
         wb(`REG_OFFSETS, 1'b0, 32'h0);
         e = 12'((1 << (i + 3)) - 1);
         `CHK(q, {4'h0, e, 4'h0, e})
         wb(`REG_STATUS, 1'b0, 32'h0);
         cf = config_t'(q[29:16]);
         `CHK({cf.serial_prog, cf.write_narrow}, {i[2], i[0]})
         `CHK({cf.read_narrow, cf.sync_flags}, {i[1], i[2]})
      end
      pins.offset_load_select_n <= 1'b0;
      ck(5);
      wr(18'h00005);
      wr(18'h0000A);
      rd_ev();
      `CHK(read_data_out_o, 18'h00005)
      pins.offset_load_select_n <= 1'b1;
      ck(5);
      wb(`REG_OFFSETS, 1'b0, 32'h0);
      `CHK(q, 32'h000A0005)
      wr(18'h1A5A5);
      wr(18'h2C3C3);
      wr(18'h0F0F0);
      ck(3);
      `CHK(almost_empty_flag_o, 1'b1)
      rd_ev();
      `CHK(read_data_out_o, 18'h1A5A5)
      `CHK(almost_empty_flag_o, 1'b0)
      pins.mark <= 1'b1;
      ck(2);
      pins.mark <= 1'b0;
      ck(5);
      rd_ev();
      `CHK(read_data_out_o, 18'h2C3C3)
      pins.retransmit_request_n <= 1'b0;
      rd_ev();
      pins.retransmit_request_n <= 1'b1;
      `CHK(empty_indicator_n_o, 1'b0)
      rd_ev();
      `CHK(read_data_out_o, 18'h2C3C3)
      oe_n <= 1'b1;
      pins.partial_clear_n <= 1'b0;
      ck(8);
      `CHK(read_data_oe_n_o, 1'b1)
      pins.partial_clear_n <= 1'b1;
      oe_n <= 1'b0;
      ck(6);
      `CHK(read_data_out_o, 18'h0)
      `CHK(read_data_oe_n_o, 1'b0)
      wb(`REG_OFFSETS, 1'b0, 32'h0);
      `CHK(q, 32'h000A0005)
      repeat (2042) wr(18'h3FFFF);
      ck(3);
      `CHK(almost_full_flag_o, 1'b1)
      wr(18'h3FFFF);
      ck(3);
      `CHK(almost_full_flag_o, 1'b0)
      repeat (5) wr(18'h3FFFF);
      `CHK(wr_full_o, 1'b1)
      wr(18'h3FFFF);
      ck(2);
      `CHK(irq_o, 1'b0)
      wb(`REG_IRQ_MASK, 1'b1, 32'h1);
      ck(1);
      `CHK(irq_o, 1'b1)
      wb(`REG_IRQ_STAT, 1'b1, 32'h1);
      ck(1);
      `CHK(irq_o, 1'b0)
      wb(8'h20, 1'b0, 32'h0);
      `CHK(q, 32'h0)
      give_verdict();
   end
endmodule : fifo_control_flags_reset_tb

/* bench/fifo_far_side.sv */
`timescale 1ns/1ps
// reader side: one read clock pulse per request, high 4 and low 4 cycles,
// so the filtered pin always shows a clean rise to the block
module fifo_far_side (
   input  wire logic clk_i,
   input  wire logic rd_req_i,
   output logic      read_clock_o,
   output logic      busy_o
);
   logic [3:0] cnt_q = 4'h0;

   always_ff @(posedge clk_i)
   begin
      if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
      else if (rd_req_i)
         cnt_q <= 4'h8;
   end

   // clock stands low between reads, never runs free
   assign read_clock_o = (cnt_q > 4'h4);
   assign busy_o       = (cnt_q != 4'h0);
endmodule : fifo_far_side

/* design/fifo_control_flags_reset.sv */
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fifo_ctl_defs.svh"
module fifo_control_flags_reset
   import fifo_ctl_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   input  wire pins_t       pins_i,
   input  wire logic        output_drive_n_i,
   input  wire logic        wr_en_i,
   input  wire logic [17:0] wr_data_i,
   output logic             wr_full_o,
   output logic      [17:0] read_data_out_o,
   output logic             read_data_oe_n_o,
   output logic             empty_indicator_n_o,
   output logic             almost_empty_flag_o,
   output logic             almost_full_flag_o
);

   logic [8:0] mem [0:4095];

   state_t q;
   state_t d;

   logic        mem_we;
   logic        mem_we2;
   logic [11:0] mem_wa;
   logic [11:0] mem_wa2;
   logic [17:0] mem_wd;

   function automatic logic [11:0] default_offset(input logic [2:0] sel);
      logic [11:0] v;
      v = `DEF_OFS0;
      case (sel)
         3'h0: v = `DEF_OFS0;
         3'h1: v = `DEF_OFS1;
         3'h2: v = `DEF_OFS2;
         3'h3: v = `DEF_OFS3;
         3'h4: v = `DEF_OFS4;
         3'h5: v = `DEF_OFS5;
         3'h6: v = `DEF_OFS6;
         default: v = `DEF_OFS7;
      endcase
      return v;
   endfunction : default_offset

   // words held, in 9-bit units
   function automatic logic [12:0] fill(input logic [12:0] w,
                                        input logic [12:0] r);
      return 13'(w - r);
   endfunction : fill

   function automatic logic [1:0] unit_size(input logic narrow);
      return narrow ? 2'h1 : 2'h2;
   endfunction : unit_size

   logic [12:0] cnt;
   logic [12:0] free;
   logic        data_empty;
   logic        data_full;
   logic        rd_ev;
   logic        rd_gate;
   logic        in_full_rst;
   logic        in_part_rst;
   logic        ofs_mode;
   logic        wr_acc;
   logic        bus_req;
   logic        bus_wr;
   logic [3:0]  ev;
   logic [3:0]  clr;
   logic [12:0] r1;
   logic [12:0] ae_cnt;
   logic        ae_now;
   logic        af_now;

   always_comb
   begin
      d = q;
      mem_we  = 1'b0;
      mem_we2 = 1'b0;
      mem_wa  = q.wptr[11:0];
      mem_wa2 = 12'(q.wptr[11:0] + 12'h001);
      mem_wd  = wr_data_i;
      ev  = 4'h0;
      clr = 4'h0;

      // three-stage pin filter: a level counts once stages 2 and 3 agree
      d.s1 = pins_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.f  = pins_t'((q.s2 & q.s3) | (q.f & (q.s2 | q.s3)));
      d.rclk_prev = q.f.read_clock;

      in_full_rst = ~q.f.full_reset_n;
      in_part_rst = ~q.f.partial_clear_n;
      ofs_mode    = ~q.f.offset_load_select_n;

      cnt  = fill(q.wptr, q.rptr);
      free = 13'(`DEPTH_CNT - cnt);
      data_empty = cnt < {11'h000, unit_size(q.cfg.read_narrow)};
      data_full  = free < {11'h000, unit_size(q.cfg.write_narrow)};

      // rising edge of read clock or, in async mode, of read strobe
      rd_ev   = q.f.read_clock & ~q.rclk_prev;
      // async port: gate ignored, far side ties it active
      rd_gate = q.cfg.async_read | ~q.f.read_enable_n;

      // write side
      wr_acc = 1'b0;
      if (wr_en_i && !in_full_rst && !in_part_rst)
      begin
         if (ofs_mode)
         begin
            // serial method owns the offsets; parallel writes ignored
            if (!q.cfg.serial_prog)
            begin
               if (q.ofs_wsel)
                  d.full_ofs = wr_data_i[11:0];
               else
                  d.empty_ofs = wr_data_i[11:0];
               d.ofs_wsel = ~q.ofs_wsel;
            end
         end
         else if (data_full || !q.ctrl_wen)
         begin
            ev[`IRQ_OVERFLOW] = data_full;
         end
         else
         begin
            wr_acc  = 1'b1;
            mem_we  = 1'b1;
            mem_we2 = ~q.cfg.write_narrow;
            d.wptr  = 13'(q.wptr + {11'h000,
                                    unit_size(q.cfg.write_narrow)});
         end
      end

      // mark the present read position
      if (q.f.mark)
      begin
         d.mark_ptr   = q.rptr;
         d.mark_valid = 1'b1;
      end

      // read side
      r1 = 13'(q.rptr + 13'h0001);
      if (rd_ev && !in_full_rst && !in_part_rst)
      begin
         d.empty_hold = 1'b0;
         if (!q.f.retransmit_request_n)
         begin
            d.rptr = q.mark_valid ? q.mark_ptr : 13'h0000;
            d.empty_hold = 1'b1;
            ev[`IRQ_REWIND] = 1'b1;
         end
         else if (rd_gate)
         begin
            if (ofs_mode)
            begin
               d.dout = {6'h00, q.ofs_rsel ? q.full_ofs : q.empty_ofs};
               d.ofs_rsel = ~q.ofs_rsel;
            end
            else if (data_empty)
            begin
               ev[`IRQ_UNDERFLOW] = 1'b1;
            end
            else if (q.cfg.read_narrow)
            begin
               d.dout = {9'h000, mem[q.rptr[11:0]]};
               d.rptr = r1;
            end
            else
            begin
               d.dout = {mem[r1[11:0]], mem[q.rptr[11:0]]};
               d.rptr = 13'(q.rptr + 13'h0002);
            end
         end
      end

      // flag comparison against the programmed offsets
      ae_cnt = free;
      ae_now = cnt >= {1'b0, q.empty_ofs};
      af_now = ae_cnt > {1'b0, q.full_ofs};
      // sync timing only moves a flag on the port that affects it
      if (!q.cfg.sync_flags || rd_ev)
         d.ae = ae_now;
      if (!q.cfg.sync_flags || wr_acc)
         d.af = af_now;
      ev[`IRQ_NEAR_FULL] = q.af & ~d.af;

      // partial reset: data cleared, settings and offsets kept
      if (in_part_rst)
      begin
         d.wptr       = 13'h0000;
         d.rptr       = 13'h0000;
         d.dout       = 18'h00000;
         d.mark_valid = 1'b0;
         d.empty_hold = 1'b0;
         d.ofs_wsel   = 1'b0;
         d.ofs_rsel   = 1'b0;
         d.ae         = 1'b0;
         d.af         = 1'b1;
         d.cfg        = q.cfg;
         d.empty_ofs  = q.empty_ofs;
         d.full_ofs   = q.full_ofs;
      end

      // full reset: clear data and sample every mode pin
      if (in_full_rst)
      begin
         d.wptr       = 13'h0000;
         d.rptr       = 13'h0000;
         d.dout       = 18'h00000;
         d.mark_valid = 1'b0;
         d.empty_hold = 1'b0;
         d.ofs_wsel   = 1'b0;
         d.ofs_rsel   = 1'b0;
         d.ae         = 1'b0;
         d.af         = 1'b1;
         d.cfg.fall_through = q.f.fall_through_mode;
         d.cfg.write_narrow = q.f.input_width_select;
         d.cfg.read_narrow  = q.f.output_width_select;
         d.cfg.async_read   = ~q.f.async_read_sel_n;
         d.cfg.async_write  = ~q.f.async_write_sel_n;
         d.cfg.default_sel  = {q.f.offset_load_select_n,
                               q.f.default_offset_sel_b,
                               q.f.default_offset_sel_a};
         d.cfg.serial_prog  = q.f.offset_load_select_n;
         d.cfg.big_endian   = ~q.f.big_endian_sel_n;
         d.cfg.zero_latency = q.f.zero_latency_sel;
         d.cfg.parity       = q.f.parity_sel;
         d.cfg.sync_flags   = q.f.flag_timing_select;
         d.cfg.spare        = 1'b0;
         d.empty_ofs = default_offset(d.cfg.default_sel);
         d.full_ofs  = default_offset(d.cfg.default_sel);
      end

      // bus slave: answer one cycle after the request, then drop
      bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
      bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
      d.ack   = bus_req;
      d.rdat  = 32'h00000000;
      if (bus_req)
      begin
         case ({wb_adr_i[7:2], 2'b00})
            `REG_CTRL:
               d.rdat = {31'h00000000, q.ctrl_wen};
            `REG_STATUS:
            begin
               d.rdat[`ST_COUNT_LSB +: 13] = cnt;
               d.rdat[`ST_EMPTY]   = data_empty | q.empty_hold;
               d.rdat[`ST_AEMPTY]  = q.ae;
               d.rdat[`ST_AFULL]   = q.af;
               d.rdat[`ST_CFG_LSB +: 14] = q.cfg;
            end
            `REG_IRQ_STAT:
               d.rdat = {28'h0000000, q.irq_stat};
            `REG_IRQ_MASK:
               d.rdat = {28'h0000000, q.irq_mask};
            `REG_OFFSETS:
            begin
               d.rdat[`OF_EMPTY_LSB +: 12] = q.empty_ofs;
               d.rdat[`OF_FULL_LSB +: 12]  = q.full_ofs;
            end
            default:
               d.rdat = 32'h00000000;
         endcase
         if (bus_wr)
         begin
            case ({wb_adr_i[7:2], 2'b00})
               `REG_CTRL:
                  d.ctrl_wen = wb_dat_i[0];
               `REG_IRQ_STAT:
                  clr = wb_dat_i[3:0];
               `REG_IRQ_MASK:
                  d.irq_mask = wb_dat_i[3:0];
               default:
                  d.ctrl_wen = q.ctrl_wen;
            endcase
         end
      end
      // a new event outweighs a clear in the same cycle
      d.irq_stat = (q.irq_stat & ~clr) | ev;
   end

   // memory write needs both units when the write port is 18 bits
   always_ff @(posedge clk_i)
   begin
      if (mem_we)
         mem[mem_wa] <= mem_wd[8:0];
      if (mem_we2)
         mem[mem_wa2] <= mem_wd[17:9];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.s1 <= '1;
         q.s2 <= '1;
         q.s3 <= '1;
         q.f  <= '1;
         q.rclk_prev <= 1'b1;
         q.empty_ofs <= `DEF_OFS0;
         q.full_ofs  <= `DEF_OFS0;
         q.af        <= 1'b1;
         q.ctrl_wen  <= `CTRL_RST;
         q.irq_mask  <= `IRQ_MASK_RST;
      end
      else
      begin
         q <= d;
      end
   end

   // drive control needs no clock and ignores both resets
   assign read_data_oe_n_o    = output_drive_n_i;
   assign read_data_out_o     = q.dout;
   assign empty_indicator_n_o = ~(fill(q.wptr, q.rptr) <
      {11'h000, unit_size(q.cfg.read_narrow)} | q.empty_hold);
   assign almost_empty_flag_o = q.ae;
   assign almost_full_flag_o  = q.af;
   assign wr_full_o           = data_full;
   assign wb_ack_o            = q.ack;
   assign wb_dat_o            = q.rdat;
   assign irq_o               = |(q.irq_stat & q.irq_mask);

endmodule : fifo_control_flags_reset

/* design/fifo_ctl_defs.svh */
`ifndef FIFO_CTL_DEFS_SVH
`define FIFO_CTL_DEFS_SVH

// storage in 9-bit units
`define UNIT_W        9
`define DEPTH_UNITS   4096
`define PTR_W         13
`define OFS_W         12
`define DEPTH_CNT     13'h1000

// register byte offsets
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_IRQ_STAT  8'h08
`define REG_IRQ_MASK  8'h0C
`define REG_OFFSETS   8'h10

// register reset values
`define CTRL_RST      1'b1
`define IRQ_MASK_RST  4'h0

// interrupt status bit positions
`define IRQ_OVERFLOW  0
`define IRQ_UNDERFLOW 1
`define IRQ_REWIND    2
`define IRQ_NEAR_FULL 3

// status register field positions
`define ST_COUNT_LSB  0
`define ST_EMPTY      13
`define ST_AEMPTY     14
`define ST_AFULL      15
`define ST_CFG_LSB    16

// offsets register field positions
`define OF_EMPTY_LSB  0
`define OF_FULL_LSB   16

// eight default flag offsets chosen at full reset
`define DEF_OFS0      12'h007
`define DEF_OFS1      12'h00F
`define DEF_OFS2      12'h01F
`define DEF_OFS3      12'h03F
`define DEF_OFS4      12'h07F
`define DEF_OFS5      12'h0FF
`define DEF_OFS6      12'h1FF
`define DEF_OFS7      12'h3FF

`endif

/* design/fifo_ctl_pkg.sv */
package fifo_ctl_pkg;

   // pins from outside the clock domain, filtered before use
   typedef struct packed {
      logic full_reset_n;
      logic partial_clear_n;
      logic offset_load_select_n;
      logic default_offset_sel_a;
      logic default_offset_sel_b;
      logic flag_timing_select;
      logic fall_through_mode;
      logic input_width_select;
      logic output_width_select;
      logic async_read_sel_n;
      logic async_write_sel_n;
      logic big_endian_sel_n;
      logic zero_latency_sel;
      logic parity_sel;
      logic mark;
      logic retransmit_request_n;
      logic read_enable_n;
      logic read_clock;
   } pins_t;

   // settings latched during full reset
   typedef struct packed {
      logic       fall_through;
      logic       write_narrow;
      logic       read_narrow;
      logic       async_read;
      logic       async_write;
      logic [2:0] default_sel;
      logic       serial_prog;
      logic       big_endian;
      logic       zero_latency;
      logic       parity;
      logic       sync_flags;
      logic       spare;
   } config_t;

   typedef struct packed {
      pins_t        s1;
      pins_t        s2;
      pins_t        s3;
      pins_t        f;
      logic         rclk_prev;
      config_t      cfg;
      logic [11:0]  empty_ofs;
      logic [11:0]  full_ofs;
      logic         ofs_wsel;
      logic         ofs_rsel;
      logic [12:0]  wptr;
      logic [12:0]  rptr;
      logic [12:0]  mark_ptr;
      logic         mark_valid;
      logic         empty_hold;
      logic [17:0]  dout;
      logic         ae;
      logic         af;
      logic [3:0]   irq_stat;
      logic [3:0]   irq_mask;
      logic         ctrl_wen;
      logic         ack;
      logic [31:0]  rdat;
   } state_t;

endpackage : fifo_ctl_pkg
